// *** logic/lmec_pkg.sv ***
package lmec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_LENGTH_CTRL = 8'h10;
   localparam logic [7:0] IDX_ACT_CODE = 8'h11;
   localparam logic [7:0] IDX_DEACT_CODE = 8'h12;
   localparam logic [7:0] IDX_ERR_CTRL = 8'h13;
   localparam logic [7:0] IDX_INT_MASK = 8'h14;
   localparam logic [7:0] IDX_EDGE_SEL = 8'h16;
   localparam logic [7:0] IDX_LIVE_STATUS = 8'h17;
   localparam logic [7:0] IDX_INT_STATUS = 8'h18;
   localparam logic [7:0] IDX_COUNT_LOW = 8'h19;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'h1a;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_ACT_CODE = 8'h01;
   localparam logic [7:0] RST_DEACT_CODE = 8'h09;
   localparam logic [3:0] RST_LENGTH_CTRL = 4'h1;
   localparam logic [7:0] RST_INT_MASK = 8'hff;
   localparam logic [7:0] RST_EDGE_SEL = 8'h00;
   localparam logic [7:0] RST_ERR_CTRL = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ACT_LEN_LSB = 2;
   localparam int DEACT_LEN_LSB = 0;
   localparam int VIOL_INS_BIT = 6;
   localparam int PAT_PATTERN_ERROR_INSERT_BIT = 5;
   localparam int EXZ_RULE_BIT = 4;
   localparam int ERR_SEL_LSB = 2;
   localparam int REPORT_MODE_BIT = 1;
   localparam int XFER_BIT = 0;
   localparam logic [7:0] ERR_CTRL_RW_MASK = 8'h7f;

   ////////////////////////////////////////////////////////////////////////////
   // Error type select codes
   localparam logic [1:0] SEL_PATTERN = 2'h0;
   localparam logic [1:0] SEL_EXCESS_ZERO = 2'h1;
   localparam logic [1:0] SEL_CODE_VIOL = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic pattern_err;
      logic excess_zero;
      logic code_viol;
   } lmec_err_evt_t;

   typedef struct packed {
      logic [7:0] rx_activate_pattern;
      logic [1:0] rx_activate_length;
      logic [7:0] rx_deactivate_pattern;
      logic [1:0] rx_deactivate_length;
      logic excess_zero_rule_select;
   } lmec_rx_cfg_t;

   typedef struct packed {
      logic violation_insert;
      logic pattern_error_insert;
   } lmec_ins_t;

endpackage

// *** logic/lmec_regs.sv ***
`timescale 1ns/1ps

// Operation
// - A writable 8-bit activate code, of which the low 5 to 8 bits are the searched pattern, resets to 00001.
// - A writable 8-bit deactivate code, of which the low 5 to 8 bits are the searched pattern, resets to 001001.
// - Two-bit length fields choose 5, 6, 7 or 8 bits; activate defaults to 5 and deactivate to 6.
// - A 0-to-1 write of the violation-insert bit inserts exactly one bipolar violation; re-arm by clearing it.
// - A 0-to-1 write of the pattern-error-insert bit corrupts exactly one pattern bit; re-arm by clearing it.
// - The excess-zero rule select bit picks ANSI when 0 and FCC when 1.
// - The error-type select routes pattern, excess-zero, code-violation or both of the latter to the counter.
// - The report mode bit picks manual reporting at 0 and automatic at 1, and resets to 0.
// - A transfer copies the error count into the two result registers and restarts the counter from that cycle's events.
// - Each mask bit enables its interrupt at 0, blocks it at 1, resets to 1; bit 7 masks equalizer range.
// - Mask bit 6 gates activate-code detection and bit 5 gates deactivate-code detection.
// - Mask bit 4 gates pattern sync and bit 3 gates transmit clock loss.
// - Mask bit 2 gates line driver failure.
// - Mask bit 1 gates alarm indication signal and bit 0 gates loss of signal.
// - A status event is a 0-to-1 change of its live bit, or either change where edge select is set.
module lmec_regs
   import lmec_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] live_status,
   input wire lmec_err_evt_t err_evt,
   input wire logic report_tick,
   output lmec_rx_cfg_t rx_cfg,
   output lmec_ins_t tx_insert,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = 8'(a >> 2);
      idx_ok = (a[1:0] == 2'h0) && (32'(a) < 32'h400) &&
               ((i >= IDX_LENGTH_CTRL && i <= IDX_INT_MASK) || (i >= IDX_EDGE_SEL && i <= IDX_COUNT_HIGH));
   endfunction

   function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = 8'(a >> 2);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0] act_code_reg;
   logic [7:0] deact_code_reg;
   logic [3:0] length_reg;
   logic [7:0] err_ctrl_reg;
   logic [7:0] mask_reg;
   logic [7:0] edge_sel_reg;
   logic [7:0] int_status_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] result_reg;
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] live_prev_reg;

   logic [ADDR_W-1:0] awaddr_reg;
   logic aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic w_held_reg;

   logic wr_fire;
   logic wr_ok;
   logic [7:0] wr_idx;
   logic [7:0] wr_byte;
   logic xfer;
   logic [1:0] evt_sum;
   logic [7:0] status_evt;
   logic [CNT_W:0] count_sum;
   logic [7:0] rd_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture; address and data taken in either order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= '0;
         s_axi_awready <= 1'b0;
      end else if (ce) begin
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b0;
         end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         w_held_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_wready <= 1'b0;
      end else if (ce) begin
         if (wr_fire) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b0;
         end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else begin
            s_axi_wready <= !w_held_reg && !s_axi_bvalid;
         end
      end
   end

   // Registers are one byte wide, so only lane 0 carries a write
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_ok = wr_fire && idx_ok(awaddr_reg) && wstrb_reg[0];
   assign wr_idx = idx_of(awaddr_reg);
   assign wr_byte = wdata_reg[7:0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= idx_ok(awaddr_reg) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code and length storage
   // One process per register keeps each reset value beside its write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         act_code_reg <= RST_ACT_CODE;
      end else if (ce && wr_ok && wr_idx == IDX_ACT_CODE) begin
         act_code_reg <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         deact_code_reg <= RST_DEACT_CODE;
      end else if (ce && wr_ok && wr_idx == IDX_DEACT_CODE) begin
         deact_code_reg <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         length_reg <= RST_LENGTH_CTRL;
      end else if (ce && wr_ok && wr_idx == IDX_LENGTH_CTRL) begin
         length_reg <= wr_byte[3:0];
      end
   end

   // Masks reset closed so nothing interrupts before software opens them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_reg <= RST_INT_MASK;
      end else if (ce && wr_ok && wr_idx == IDX_INT_MASK) begin
         mask_reg <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         edge_sel_reg <= RST_EDGE_SEL;
      end else if (ce && wr_ok && wr_idx == IDX_EDGE_SEL) begin
         edge_sel_reg <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_cfg <= '0;
      end else if (ce) begin
         rx_cfg.rx_activate_pattern <= act_code_reg;
         rx_cfg.rx_deactivate_pattern <= deact_code_reg;
         rx_cfg.rx_activate_length <= length_reg[ACT_LEN_LSB +: 2];
         rx_cfg.rx_deactivate_length <= length_reg[DEACT_LEN_LSB +: 2];
         rx_cfg.excess_zero_rule_select <= err_ctrl_reg[EXZ_RULE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error control; 0-to-1 writes fire one-shot actions
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_ctrl_reg <= RST_ERR_CTRL;
      end else if (ce && wr_ok && wr_idx == IDX_ERR_CTRL) begin
         err_ctrl_reg <= wr_byte & ERR_CTRL_RW_MASK;
      end
   end

   // Held bit gives only one pulse; software must clear and set again
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_insert <= '0;
      end else if (ce) begin
         tx_insert.violation_insert <= wr_ok && wr_idx == IDX_ERR_CTRL &&
            wr_byte[VIOL_INS_BIT] && !err_ctrl_reg[VIOL_INS_BIT];
         tx_insert.pattern_error_insert <= wr_ok && wr_idx == IDX_ERR_CTRL &&
            wr_byte[PAT_PATTERN_ERROR_INSERT_BIT] && !err_ctrl_reg[PAT_PATTERN_ERROR_INSERT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error counter
   // Manual mode transfers on a rising write; auto mode on the report tick
   assign xfer = err_ctrl_reg[REPORT_MODE_BIT] ? report_tick
      : (wr_ok && wr_idx == IDX_ERR_CTRL && wr_byte[XFER_BIT] && !err_ctrl_reg[XFER_BIT]);

   always_comb begin
      evt_sum = 2'h0;
      unique case (err_ctrl_reg[ERR_SEL_LSB +: 2])
         SEL_PATTERN: evt_sum = {1'b0, err_evt.pattern_err};
         SEL_EXCESS_ZERO: evt_sum = {1'b0, err_evt.excess_zero};
         SEL_CODE_VIOL: evt_sum = {1'b0, err_evt.code_viol};
         SEL_BOTH: evt_sum = 2'({1'b0, err_evt.code_viol} + {1'b0, err_evt.excess_zero});
      endcase
   end

   // Saturates rather than wrapping so a long interval never reads small
   always_comb begin
      count_sum = {1'b0, count_reg} + (CNT_W+1)'(evt_sum);
   end

   // Result moves only on a transfer, so software reads a settled count
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_reg <= '0;
      end else if (ce && xfer) begin
         result_reg <= count_reg;
      end
   end

   // A transfer cycle's own events start the next interval
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else if (ce) begin
         if (xfer) begin
            count_reg <= CNT_W'(evt_sum);
         end else if (count_sum[CNT_W]) begin
            count_reg <= '1;
         end else begin
            count_reg <= count_sum[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Live status sync and event detection
   // Two flops before anything reads the pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (ce) begin
         sync1_reg <= live_status;
         sync2_reg <= sync1_reg;
      end
   end

   // Resets low like the idle pins, so release gives no false edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         live_prev_reg <= '0;
      end else if (ce) begin
         live_prev_reg <= sync2_reg;
      end
   end

   assign status_evt = (sync2_reg & ~live_prev_reg) | (edge_sel_reg & ~sync2_reg & live_prev_reg);

   // New event wins over a same-cycle write-one-to-clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_status_reg <= '0;
      end else if (ce) begin
         if (wr_ok && wr_idx == IDX_INT_STATUS) begin
            int_status_reg <= (int_status_reg & ~wr_byte) | status_evt;
         end else begin
            int_status_reg <= int_status_reg | status_evt;
         end
      end
   end

   // Bit order: 7 equalizer, 6 activate, 5 deactivate, 4 sync, 3 clock loss, 2 driver, 1 alarm, 0 signal loss
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(int_status_reg & ~mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   // Read byte mux; the length field sits in the low nibble
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx_of(s_axi_araddr))
         IDX_LENGTH_CTRL: rd_byte = {4'h0, length_reg};
         IDX_ACT_CODE: rd_byte = act_code_reg;
         IDX_DEACT_CODE: rd_byte = deact_code_reg;
         IDX_ERR_CTRL: rd_byte = err_ctrl_reg;
         IDX_INT_MASK: rd_byte = mask_reg;
         IDX_EDGE_SEL: rd_byte = edge_sel_reg;
         IDX_LIVE_STATUS: rd_byte = sync2_reg;
         IDX_INT_STATUS: rd_byte = int_status_reg;
         IDX_COUNT_LOW: rd_byte = result_reg[7:0];
         IDX_COUNT_HIGH: rd_byte = result_reg[15:8];
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= AXI_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= idx_ok(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
            s_axi_rdata <= idx_ok(s_axi_araddr) ? {24'h0, rd_byte} : 32'h0;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // lmec_regs

// *** verif/lmec_regs_sva.sv ***
`timescale 1ns/1ps
module lmec_regs_sva
   import lmec_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire lmec_ins_t tx_insert,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////
   // Bus side
   write_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response missing");
   read_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // Registers are one byte wide
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");

   ////////////////////////////////////////
   // Line side and reset
   viol_pulse_a: assert property (
      ce && tx_insert.violation_insert |=> !tx_insert.violation_insert) else $error("violation pulse too long");
   pat_pulse_a: assert property (
      ce && tx_insert.pattern_error_insert |=> !tx_insert.pattern_error_insert) else $error("pattern pulse too long");
   reset_quiet_a: assert property (disable iff (1'b0)
      sys_rst && ce |=> !irq && !s_axi_bvalid && !s_axi_rvalid && tx_insert == '0) else $error("outputs live in reset");
endmodule // lmec_regs_sva

bind lmec_regs lmec_regs_sva sva_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_insert(tx_insert), .irq(irq));

// *** verif/lmec_tb.sv ***
`timescale 1ns/1ps
module testbench;
   import lmec_pkg::*;
   logic clk, sys_rst, ce, report_tick, irq;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] live_status;
   lmec_err_evt_t err_evt;
   lmec_rx_cfg_t rx_cfg;
   lmec_ins_t tx_insert;
   int n_mismatch = 0;
   int total_checks = 0;
   int n_viol = 0;
   int n_pat = 0;
   int cycles = 0;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   lmec_regs dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .live_status(live_status),
      .err_evt(err_evt), .report_tick(report_tick), .rx_cfg(rx_cfg), .tx_insert(tx_insert), .irq(irq));

   ////////////////////////////////////////
   // Pulse counters and hang guard
   always @(posedge clk) begin
      cycles++;
      if (tx_insert.violation_insert === 1'b1) n_viol++;
      if (tx_insert.pattern_error_insert === 1'b1) n_pat++;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Sampled at the falling edge: the handshake then lands on the next rising edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (tb !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, r);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = AXI_OKAY);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end while (tr !== 1'b1);
      rready <= 1'b0;
      chk("rdata", {24'h0, e}, d);
      chk("rresp", er, r);
   endtask

   ////////////////////////////////////////
   // Scenarios
   task automatic t_defaults;
      rd(IDX_ACT_CODE, 8'h01);
      rd(IDX_DEACT_CODE, 8'h09);
      rd(IDX_LENGTH_CTRL, 8'h01);
      rd(IDX_ERR_CTRL, 8'h00);
      rd(IDX_INT_MASK, 8'hff);
      chk("rx_cfg", {8'h01, 2'h0, 8'h09, 2'h1, 1'b0}, rx_cfg);
   endtask

   task automatic t_cfg;
      wr(IDX_ACT_CODE, 8'ha5);
      wr(IDX_DEACT_CODE, 8'h3c);
      wr(IDX_LENGTH_CTRL, 8'h0e);
      wr(IDX_ERR_CTRL, 8'h90);
      wr(8'h15, 8'h00, AXI_SLVERR);
      rd(IDX_ACT_CODE, 8'ha5);
      rd(IDX_DEACT_CODE, 8'h3c);
      rd(IDX_LENGTH_CTRL, 8'h0e);
      rd(IDX_ERR_CTRL, 8'h10);
      rd(8'h3f, 8'h00, AXI_SLVERR);
      chk("rx_cfg", {8'ha5, 2'h3, 8'h3c, 2'h2, 1'b1}, rx_cfg);
      wr(IDX_ERR_CTRL, 8'h00);
   endtask

   task automatic t_insert;
      int v0, p0;
      v0 = n_viol;
      p0 = n_pat;
      wr(IDX_ERR_CTRL, 8'h60);
      wr(IDX_ERR_CTRL, 8'h60);
      tick(3);
      chk("viol", v0 + 1, n_viol);
      chk("pat", p0 + 1, n_pat);
      wr(IDX_ERR_CTRL, 8'h00);
      wr(IDX_ERR_CTRL, 8'h40);
      tick(3);
      chk("viol", v0 + 2, n_viol);
      chk("pat", p0 + 1, n_pat);
      wr(IDX_ERR_CTRL, 8'h00);
   endtask

   // Pattern 3, excess zero 2, code violation 4; two cycles carry both of the latter
   task automatic evts;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         err_evt <= {i < 3, i < 2, 1'b1};
      end
      @(posedge clk);
      err_evt <= '0;
   endtask

   task automatic t_count;
      logic [7:0] ex [4] = '{8'd3, 8'd2, 8'd4, 8'd6};
      logic [7:0] prev;
      prev = 8'h00;
      for (int s = 0; s < 4; s++) begin
         wr(IDX_ERR_CTRL, {4'h0, s[1:0], 2'h0});
         evts();
         wr(IDX_ERR_CTRL, {4'h0, s[1:0], 2'h1});
         rd(IDX_COUNT_LOW, ex[s] + prev);
         rd(IDX_COUNT_HIGH, 8'h00);
         evts();
         wr(IDX_ERR_CTRL, {4'h0, s[1:0], 2'h1});
         rd(IDX_COUNT_LOW, ex[s] + prev);
         prev = ex[s];
      end
      // Counter now holds 6; auto mode ignores the transfer bit
      wr(IDX_ERR_CTRL, 8'h02);
      evts();
      wr(IDX_ERR_CTRL, 8'h03);
      rd(IDX_COUNT_LOW, 8'd10);
      @(posedge clk);
      report_tick <= 1'b1;
      @(posedge clk);
      report_tick <= 1'b0;
      rd(IDX_COUNT_LOW, 8'd9);
      wr(IDX_ERR_CTRL, 8'h00);
   endtask

   // Frozen cycles must not count; a write with lane 0 off must not land
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      evts();
      @(posedge clk);
      ce <= 1'b1;
      evts();
      wr(IDX_ERR_CTRL, 8'h01);
      rd(IDX_COUNT_LOW, 8'd3);
      wstrb <= 4'h0;
      wr(IDX_ACT_CODE, 8'h5a);
      wstrb <= 4'hf;
      rd(IDX_ACT_CODE, 8'ha5);
   endtask

   // Waits cover the two-stage status synchroniser
   task automatic t_irq;
      wr(IDX_EDGE_SEL, 8'h00);
      for (int b = 0; b < 8; b++) begin
         live_status[b] <= 1'b1;
         tick(8);
         chk("irq masked", 1'b0, irq);
         rd(IDX_LIVE_STATUS, 8'h01 << b);
         wr(IDX_INT_MASK, ~(8'h01 << b));
         tick(3);
         chk("irq open", 1'b1, irq);
         wr(IDX_INT_STATUS, 8'h01 << b);
         tick(3);
         chk("irq cleared", 1'b0, irq);
         live_status[b] <= 1'b0;
         tick(8);
         rd(IDX_INT_STATUS, 8'h00);
         wr(IDX_INT_MASK, 8'hff);
      end
      wr(IDX_EDGE_SEL, 8'h01);
      wr(IDX_INT_MASK, 8'hfe);
      live_status[0] <= 1'b1;
      tick(8);
      wr(IDX_INT_STATUS, 8'h01);
      live_status[0] <= 1'b0;
      tick(8);
      chk("irq fall", 1'b1, irq);
   endtask

   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, report_tick} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      live_status = '0;
      err_evt = '0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      tick(3);
      t_defaults();
      t_cfg();
      t_insert();
      t_count();
      t_freeze();
      t_irq();
      wrap_up();
   end
endmodule // testbench
